// [verilog/fcfm_monitor.sv]
// Communication fault monitor of a fieldbus slave: counters, coded faults, registers.
// Assumes frame and sync event pulses and pin levels from outside the clock domain.
`include "fcfm_defs.svh"

// Functional notes
// - Count frame losses in upper counter half
// - Upstream-marked frames raise transfer warning
// - Separate transfer-error and invalid-frame counters
// - Marked frames skip receive error counter
// - Operational state: frame absence raises timeout
// - Description load failure faults; version readable
// - EEPROM communication failure raises read fault
// - Wrong content or update failure faults
// - Interface init failure raises external fault
// - Sync cycle must be base multiple
// - Sync deviation over threshold raises fault
module fcfm_monitor #(
   parameter int CNT_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   input wire logic sync_evt_in,
   input wire logic frame_evt_in,
   input wire logic frame_lost_in,
   input wire logic frame_marked_in,
   input wire logic frame_invalid_in,
   input wire logic frame_xfer_err_in,
   input wire logic desc_load_fail_in,
   input wire logic [15:0] desc_version_in,
   input wire logic eeprom_comm_fail_in,
   input wire logic eeprom_content_bad_in,
   input wire logic init_fail_in,
   input wire logic [15:0] interface_firmware_version_in,
   output logic [7:0] fault_code_out,
   output logic fault_any_out
);
   // Two-stage synchronisers for all pin inputs
   localparam int NPIN = 10;
   wire [NPIN-1:0] pin_raw = {sync_evt_in, frame_evt_in, frame_lost_in, frame_marked_in, frame_invalid_in,
      frame_xfer_err_in, desc_load_fail_in, eeprom_comm_fail_in, eeprom_content_bad_in, init_fail_in};
   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;
   logic [NPIN-1:0] pin_d;
   logic [15:0] desc_ver_s1;
   logic [15:0] desc_ver;
   logic [15:0] fw_ver_s1;
   logic [15:0] fw_ver;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_d <= '0;
         desc_ver_s1 <= 16'h0;
         desc_ver <= 16'h0;
         // Good major at reset so the version check stays quiet until synced
         fw_ver_s1 <= {`FCFM_FW_MAJOR, 8'h00};
         fw_ver <= {`FCFM_FW_MAJOR, 8'h00};
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
         desc_ver_s1 <= desc_version_in;
         desc_ver <= desc_ver_s1;
         fw_ver_s1 <= interface_firmware_version_in;
         fw_ver <= fw_ver_s1;
      end
   end

   // Rising edges give one-cycle events; levels used directly
   wire [NPIN-1:0] rise = pin_s2 & ~pin_d;
   wire sync_evt = rise[9];
   wire frame_evt = rise[8];
   wire lost_evt = rise[7];
   wire marked_evt = rise[6];
   wire invalid_evt = rise[5];
   wire xfer_evt = rise[4];
   wire desc_fail = pin_s2[3];
   wire ee_comm_fail = pin_s2[2];
   wire ee_content_bad = pin_s2[1];
   wire init_fail = pin_s2[0];

   // Software registers
   logic [8:0] mask;
   logic op_state;
   logic [7:0] update_timeout_multiplier;
   logic [15:0] sync_error_threshold;
   logic [7:0] fault_code;
   logic [8:0] fault;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   wire wr_mask = wr_in && hit(addr_in, `FCFM_ADDR_MASK);
   wire wr_ctrl = wr_in && hit(addr_in, `FCFM_ADDR_CTRL);
   wire wr_mult = wr_in && hit(addr_in, `FCFM_ADDR_MULT);
   wire wr_thr = wr_in && hit(addr_in, `FCFM_ADDR_THRESH);
   wire rd_fault = rd_in && hit(addr_in, `FCFM_ADDR_FAULT);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mask <= '0;
         op_state <= 1'b0;
         update_timeout_multiplier <= `FCFM_MULT_RESET;
         sync_error_threshold <= `FCFM_THRESH_RESET;
      end else begin
         if (wr_mask)
            mask <= wdata_in[8:0];
         if (wr_ctrl)
            op_state <= wdata_in[`FCFM_CTRL_OP_BIT];
         if (wr_mult)
            update_timeout_multiplier <= wdata_in[7:0];
         if (wr_thr)
            sync_error_threshold <= wdata_in[15:0];
      end
   end

   // Diagnostic counters
   logic [CNT_W-1:0] loss_cnt;
   logic [CNT_W-1:0] xfer_cnt;
   logic [CNT_W-1:0] inval_cnt;
   logic [CNT_W-1:0] rxerr_cnt;
   wire local_rx_err = invalid_evt && !pin_s2[6];

   fcfm_cnt #(.WIDTH(CNT_W)) u_loss (.clk_in(clk_in), .rst_in(rst_in), .inc_in(lost_evt), .count_out(loss_cnt));
   fcfm_cnt #(.WIDTH(CNT_W)) u_xfer (.clk_in(clk_in), .rst_in(rst_in), .inc_in(xfer_evt), .count_out(xfer_cnt));
   fcfm_cnt #(.WIDTH(CNT_W)) u_inval (.clk_in(clk_in), .rst_in(rst_in), .inc_in(invalid_evt),
      .count_out(inval_cnt));
   fcfm_cnt #(.WIDTH(CNT_W)) u_rxerr (.clk_in(clk_in), .rst_in(rst_in), .inc_in(local_rx_err),
      .count_out(rxerr_cnt));

   // Sync period measurement and update timeout
   fcfm_sync_if sif ();
   logic [31:0] since_sync;
   logic [31:0] since_frame;
   logic [31:0] cycle_len;
   logic [31:0] period_q;
   logic period_valid_q;
   logic sync_seen;
   assign sif.period = period_q;
   assign sif.period_valid = period_valid_q;
   wire [31:0] timeout_lim = 32'(cycle_len * {24'h0, update_timeout_multiplier});
   wire timeout_evt = op_state && (cycle_len != 32'h0) && (since_frame == timeout_lim);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         since_sync <= 32'h0;
         since_frame <= 32'h0;
         cycle_len <= 32'h0;
         period_q <= 32'h0;
         period_valid_q <= 1'b0;
         sync_seen <= 1'b0;
      end else begin
         // No period is measured before a first sync has been seen
         period_valid_q <= sync_evt && op_state && sync_seen;
         if (sync_evt) begin
            since_sync <= 32'h1;
            sync_seen <= 1'b1;
            if (sync_seen) begin
               cycle_len <= since_sync;
               period_q <= since_sync;
            end
         end else if (since_sync != 32'hFFFFFFFF)
            since_sync <= since_sync + 32'h1;
         if (frame_evt || !op_state)
            since_frame <= 32'h0;
         else if (since_frame != 32'hFFFFFFFF)
            since_frame <= since_frame + 32'h1;
      end
   end

   fcfm_cycle_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .threshold_in(sync_error_threshold), .sif(sif));

   // Fault events and latch; set wins over read-clear
   wire [8:0] fault_set;
   assign fault_set[fcfm_pkg::FCFM_F_LOSS] = lost_evt;
   assign fault_set[fcfm_pkg::FCFM_F_XFER] = marked_evt;
   assign fault_set[fcfm_pkg::FCFM_F_TIMEOUT] = timeout_evt;
   assign fault_set[fcfm_pkg::FCFM_F_DESC] = desc_fail;
   assign fault_set[fcfm_pkg::FCFM_F_EE_RD] = ee_comm_fail;
   assign fault_set[fcfm_pkg::FCFM_F_EE_UPD] = ee_content_bad && !ee_comm_fail;
   assign fault_set[fcfm_pkg::FCFM_F_INIT] = init_fail || (fw_ver[15:8] != `FCFM_FW_MAJOR);
   assign fault_set[fcfm_pkg::FCFM_F_CYC_SET] = sif.set_bad && op_state;
   assign fault_set[fcfm_pkg::FCFM_F_CYC_ERR] = sif.dev_bad;

   function automatic logic [7:0] code_of(input logic [8:0] v);
      logic [7:0] c;
      c = `FCFM_CODE_NONE;
      if (v[8]) c = `FCFM_CODE_CYC_ERR;
      if (v[7]) c = `FCFM_CODE_CYC_SET;
      if (v[6]) c = `FCFM_CODE_INIT;
      if (v[5]) c = `FCFM_CODE_EE_UPD;
      if (v[4]) c = `FCFM_CODE_EE_RD;
      if (v[3]) c = `FCFM_CODE_DESC;
      if (v[2]) c = `FCFM_CODE_TIMEOUT;
      if (v[1]) c = `FCFM_CODE_XFER;
      if (v[0]) c = `FCFM_CODE_LOSS;
      return c;
   endfunction

   wire [8:0] next_fault = (rd_fault ? 9'h000 : fault) | fault_set;
   wire [7:0] next_code = (fault_set != 9'h000) ? code_of(fault_set) : (rd_fault ? `FCFM_CODE_NONE : fault_code);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fault <= '0;
         fault_code <= `FCFM_CODE_NONE;
         irq_out <= 1'b0;
         fault_code_out <= `FCFM_CODE_NONE;
         fault_any_out <= 1'b0;
      end else begin
         fault <= next_fault;
         fault_code <= next_code;
         irq_out <= |(next_fault & mask);
         fault_code_out <= next_code;
         fault_any_out <= |next_fault;
      end
   end

   // Read mux
   wire [31:0] rd_mux =
      hit(addr_in, `FCFM_ADDR_FAULT) ? {23'h0, fault} :
      hit(addr_in, `FCFM_ADDR_CODE) ? {24'h0, fault_code} :
      hit(addr_in, `FCFM_ADDR_MASK) ? {23'h0, mask} :
      hit(addr_in, `FCFM_ADDR_CTRL) ? {31'h0, op_state} :
      hit(addr_in, `FCFM_ADDR_LOSS_CNT) ? {16'(loss_cnt), 16'h0} :
      hit(addr_in, `FCFM_ADDR_XFER_CNT) ? {16'h0, 16'(xfer_cnt)} :
      hit(addr_in, `FCFM_ADDR_INVAL_CNT) ? {16'h0, 16'(inval_cnt)} :
      hit(addr_in, `FCFM_ADDR_RXERR_CNT) ? {16'h0, 16'(rxerr_cnt)} :
      hit(addr_in, `FCFM_ADDR_MULT) ? {24'h0, update_timeout_multiplier} :
      hit(addr_in, `FCFM_ADDR_THRESH) ? {16'h0, sync_error_threshold} :
      hit(addr_in, `FCFM_ADDR_DESC_VER) ? {16'h0, desc_ver} :
      hit(addr_in, `FCFM_ADDR_FW_VER) ? {16'h0, fw_ver} :
      hit(addr_in, `FCFM_ADDR_CYCLE) ? cycle_len : 32'h0;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         rdata_out <= 32'h0;
      else
         rdata_out <= rd_in ? rd_mux : 32'h0;
   end


   // Checks on counters, fault latch, interrupt and read port
   a_marked_warn: assert property (@(posedge clk_in) disable iff (rst_in)
      marked_evt |=> fault[fcfm_pkg::FCFM_F_XFER]) else $error("marked frame missed");
   a_marked_norx: assert property (@(posedge clk_in) disable iff (rst_in)
      invalid_evt && pin_s2[6] |=> rxerr_cnt == $past(rxerr_cnt)) else $error("marked frame counted");
   a_timeout_op: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(op_state) |-> since_frame == 32'h0) else $error("timeout count not restarted");
   a_loss_count: assert property (@(posedge clk_in) disable iff (rst_in)
      lost_evt && !(&loss_cnt) |=> loss_cnt == $past(loss_cnt) + 1'b1) else $error("loss not counted");
   a_eeprom_read: assert property (@(posedge clk_in) disable iff (rst_in)
      ee_comm_fail |=> fault[fcfm_pkg::FCFM_F_EE_RD]) else $error("eeprom read fault missed");
   a_eeprom_upd: assert property (@(posedge clk_in) disable iff (rst_in)
      ee_content_bad && !ee_comm_fail |=> fault[fcfm_pkg::FCFM_F_EE_UPD]) else $error("update fault missed");
   a_desc_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      desc_fail |=> fault[fcfm_pkg::FCFM_F_DESC]) else $error("description fault missed");
   a_init_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      init_fail |=> fault[fcfm_pkg::FCFM_F_INIT]) else $error("init fault missed");
   a_fault_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
      fault[0] && !rd_fault |=> fault[0]) else $error("fault dropped");
   a_loss_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      lost_evt |=> fault[fcfm_pkg::FCFM_F_LOSS] && fault_code == `FCFM_CODE_LOSS) else $error("loss fault missed");
   a_xfer_count: assert property (@(posedge clk_in) disable iff (rst_in)
      xfer_evt && !(&xfer_cnt) |=> xfer_cnt == $past(xfer_cnt) + 1'b1) else $error("transfer error not counted");
   a_inval_count: assert property (@(posedge clk_in) disable iff (rst_in)
      invalid_evt && !(&inval_cnt) |=> inval_cnt == $past(inval_cnt) + 1'b1) else $error("invalid not counted");
   a_rxerr_count: assert property (@(posedge clk_in) disable iff (rst_in)
      local_rx_err && !(&rxerr_cnt) |=> rxerr_cnt == $past(rxerr_cnt) + 1'b1) else $error("rx error not counted");
   a_timeout_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      timeout_evt |=> fault[fcfm_pkg::FCFM_F_TIMEOUT]) else $error("timeout fault missed");
   a_frame_restart: assert property (@(posedge clk_in) disable iff (rst_in)
      frame_evt |=> since_frame == 32'h0) else $error("frame did not restart timeout count");
   a_cyc_set_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      sif.set_bad && op_state |=> fault[fcfm_pkg::FCFM_F_CYC_SET]) else $error("cycle setting fault missed");
   a_period_in_op: assert property (@(posedge clk_in) disable iff (rst_in)
      sif.period_valid |-> $past(op_state)) else $error("period checked outside op");
   a_cyc_err_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      sif.dev_bad |=> fault[fcfm_pkg::FCFM_F_CYC_ERR]) else $error("cycle error fault missed");
   a_version_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      fw_ver[15:8] != `FCFM_FW_MAJOR |=> fault[fcfm_pkg::FCFM_F_INIT]) else $error("version fault missed");
   a_fault_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_fault && fault_set == 9'h000 |=> fault == 9'h000) else $error("fault not cleared by read");
   a_irq_masked: assert property (@(posedge clk_in) disable iff (rst_in)
      irq_out == |(fault & $past(mask))) else $error("interrupt level wrong");
   a_any_level: assert property (@(posedge clk_in) disable iff (rst_in)
      fault_any_out == |fault) else $error("any-fault output wrong");
   a_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 32'h0) else $error("read data without read");
   a_ver_readable: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_in && addr_in == `FCFM_ADDR_DESC_VER |=> rdata_out == {16'h0, $past(desc_ver)}) else $error("version unreadable");
endmodule

// [verilog/fcfm_defs.svh]
// Offsets, field positions, reset values and timing counts of the fault monitor.
// Assumes a single 10 MHz clock; included by bare name.
`ifndef FCFM_DEFS_SVH
`define FCFM_DEFS_SVH

`define FCFM_CLK_HZ 10000000
`define FCFM_BASE_A_NS 125000
`define FCFM_BASE_B_NS 250000
`define FCFM_BASE_A_CYC ((`FCFM_BASE_A_NS * (`FCFM_CLK_HZ / 1000000)) / 1000)
`define FCFM_BASE_B_CYC ((`FCFM_BASE_B_NS * (`FCFM_CLK_HZ / 1000000)) / 1000)

`define FCFM_ADDR_FAULT 8'h00
`define FCFM_ADDR_CODE 8'h04
`define FCFM_ADDR_MASK 8'h08
`define FCFM_ADDR_CTRL 8'h0C
`define FCFM_ADDR_LOSS_CNT 8'h10
`define FCFM_ADDR_XFER_CNT 8'h14
`define FCFM_ADDR_INVAL_CNT 8'h18
`define FCFM_ADDR_RXERR_CNT 8'h1C
`define FCFM_ADDR_MULT 8'h20
`define FCFM_ADDR_THRESH 8'h24
`define FCFM_ADDR_DESC_VER 8'h28
`define FCFM_ADDR_FW_VER 8'h2C
`define FCFM_ADDR_CYCLE 8'h30

`define FCFM_MULT_RESET 8'h03
`define FCFM_THRESH_RESET 16'h0064
`define FCFM_FW_MAJOR 8'h09
`define FCFM_LOSS_LSB 16
`define FCFM_CTRL_OP_BIT 0

`define FCFM_CODE_NONE 8'h00
`define FCFM_CODE_LOSS 8'h84
`define FCFM_CODE_XFER 8'h85
`define FCFM_CODE_TIMEOUT 8'h86
`define FCFM_CODE_DESC 8'hB0
`define FCFM_CODE_EE_RD 8'hB1
`define FCFM_CODE_EE_UPD 8'hB2
`define FCFM_CODE_INIT 8'hC0
`define FCFM_CODE_CYC_SET 8'hD0
`define FCFM_CODE_CYC_ERR 8'hF0

`endif

// [verilog/fcfm_pkg.sv]
// Types shared by the fault monitor modules.
// Assumes nothing beyond the compiler.
package fcfm_pkg;
   typedef enum logic [3:0] {
      FCFM_F_LOSS,
      FCFM_F_XFER,
      FCFM_F_TIMEOUT,
      FCFM_F_DESC,
      FCFM_F_EE_RD,
      FCFM_F_EE_UPD,
      FCFM_F_INIT,
      FCFM_F_CYC_SET,
      FCFM_F_CYC_ERR
   } fcfm_fault_t;
   localparam int FCFM_NFAULT = 9;
   typedef logic [FCFM_NFAULT-1:0] fcfm_vec_t;
endpackage

// [verilog/fcfm_sync_if.sv]
// Carries the measured sync period and checker verdicts between modules.
// Assumes a single clock domain.
interface fcfm_sync_if;
   logic [31:0] period;
   logic period_valid;
   logic set_bad;
   logic dev_bad;
   modport meas (output period, output period_valid, input set_bad, input dev_bad);
   modport chk (input period, input period_valid, output set_bad, output dev_bad);
endinterface

// [verilog/fcfm_cnt.sv]
// Saturating event counter.
// Assumes a one-cycle increment pulse on the block clock.
module fcfm_cnt #(
   parameter int WIDTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic inc_in,
   output logic [WIDTH-1:0] count_out
);
   wire full = &count_out;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         count_out <= '0;
      else if (inc_in && !full)
         count_out <= count_out + 1'b1;
   end

   a_cnt_saturates: assert property (@(posedge clk_in) disable iff (rst_in)
      full |=> &count_out) else $error("counter wrapped");
endmodule

// [verilog/fcfm_cycle_chk.sv]
// Checks a measured sync period against the allowed bases and deviation.
// Assumes periods in system clock cycles, one valid pulse per sync event.
`include "fcfm_defs.svh"
module fcfm_cycle_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [15:0] threshold_in,
   fcfm_sync_if.chk sif
);
   logic [31:0] ref_period;
   logic have_ref;
   wire [31:0] base_a = 32'(`FCFM_BASE_A_CYC);
   wire [31:0] base_b = 32'(`FCFM_BASE_B_CYC);
   wire mult_ok = (sif.period % base_a == 32'h0) || (sif.period % base_b == 32'h0);
   wire [31:0] dev = (sif.period > ref_period) ? sif.period - ref_period : ref_period - sif.period;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sif.set_bad <= 1'b0;
         sif.dev_bad <= 1'b0;
         ref_period <= 32'h0;
         have_ref <= 1'b0;
      end else begin
         sif.set_bad <= sif.period_valid && !mult_ok;
         sif.dev_bad <= sif.period_valid && have_ref && (dev > {16'h0, threshold_in});
         if (sif.period_valid && !have_ref) begin
            ref_period <= sif.period;
            have_ref <= 1'b1;
         end
      end
   end

   a_cyc_setting: assert property (@(posedge clk_in) disable iff (rst_in)
      sif.period_valid && !mult_ok |=> sif.set_bad) else $error("bad cycle not flagged");
   a_cyc_dev: assert property (@(posedge clk_in) disable iff (rst_in)
      sif.dev_bad |-> $past(sif.period_valid)) else $error("deviation without period");
endmodule

// [sim/fcfm_far_end.sv]
// Far-side model: master sync pulses and process data frames.
// Assumes the monitor's clock; pulses last two cycles for its pin sync.
module fcfm_far_end (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic frames_in,
   input wire logic [15:0] period_in,
   output logic sync_evt_out,
   output logic frame_evt_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt;
   logic wrap;
   assign wrap = (cnt >= period_in - 16'h0001);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in || !run_in) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= wrap ? 16'h0000 : cnt + 16'h0001;
      end
   end
   // Sync each period, frame shortly after it when delivered
   assign sync_evt_out = run_in && (cnt < 16'h0002);
   assign frame_evt_out = run_in && frames_in && (cnt >= 16'h0005) && (cnt < 16'h0007);
endmodule

// [sim/fcfm_monitor_tb.sv]
// Self-checking bench for the communication fault monitor.
// Assumes the far-side model drives the sync and frame pins.
`include "fcfm_defs.svh"
module fcfm_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq, fault_any, sync_evt, frame_evt;
   logic [7:0] code;
   logic [3:0] evt = 4'h0;
   logic [3:0] lvl = 4'h0;
   logic run = 1'b0;
   logic frames = 1'b0;
   logic [15:0] period = 16'h09C4;
   logic [15:0] fw = 16'h0912;
   logic [31:0] got;
   int bad_count = 0;
   int n_compared = 0;

   always #50 clk_in = ~clk_in;

   fcfm_monitor fcfm_monitor_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .sync_evt_in(sync_evt), .frame_evt_in(frame_evt),
      .frame_lost_in(evt[0]), .frame_marked_in(evt[1]), .frame_invalid_in(evt[2]), .frame_xfer_err_in(evt[3]),
      .desc_load_fail_in(lvl[0]), .desc_version_in(16'h0123), .eeprom_comm_fail_in(lvl[1]),
      .eeprom_content_bad_in(lvl[2]), .init_fail_in(lvl[3]), .interface_firmware_version_in(fw),
      .fault_code_out(code), .fault_any_out(fault_any));

   fcfm_far_end fcfm_far_end_i (.clk_in(clk_in), .rst_in(rst_in), .run_in(run), .frames_in(frames),
      .period_in(period), .sync_evt_out(sync_evt), .frame_evt_out(frame_evt));

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 got = rdata;
   endtask

   // Event pin: two cycles high, then time to be seen
   task automatic pulse(input int b);
      @(posedge clk_in);
      evt[b] <= 1'b1;
      repeat (2) @(posedge clk_in);
      evt[b] <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic t_reset();
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h0);
      check({irq, fault_any}, 2'b00);
      reg_rd(`FCFM_ADDR_MULT);
      check(got, `FCFM_MULT_RESET);
      reg_rd(`FCFM_ADDR_THRESH);
      check(got, `FCFM_THRESH_RESET);
      reg_rd(`FCFM_ADDR_DESC_VER);
      check(got, 32'h0123);
      reg_rd(`FCFM_ADDR_FW_VER);
      check(got, 32'h0912);
      reg_rd(8'h3C);
      check(got, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_loss();
      reg_wr(`FCFM_ADDR_MASK, 32'h0);
      pulse(0);
      pulse(0);
      reg_rd(`FCFM_ADDR_LOSS_CNT);
      check(got, 32'h0002_0000);
      check({irq, fault_any, code}, {2'b01, `FCFM_CODE_LOSS});
      reg_wr(`FCFM_ADDR_MASK, 32'h1);
      repeat (2) @(posedge clk_in);
      #1 check(irq, 1'b1);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h1);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h0);
      check({irq, fault_any, code}, {2'b00, `FCFM_CODE_NONE});
      $display("loss test done");
   endtask

   task automatic t_marked();
      @(posedge clk_in);
      evt[1] <= 1'b1;
      pulse(2);
      pulse(3);
      evt[1] <= 1'b0;
      reg_rd(`FCFM_ADDR_CODE);
      check(got, `FCFM_CODE_XFER);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h2);
      reg_rd(`FCFM_ADDR_XFER_CNT);
      check(got, 32'h1);
      reg_rd(`FCFM_ADDR_INVAL_CNT);
      check(got, 32'h1);
      reg_rd(`FCFM_ADDR_RXERR_CNT);
      check(got, 32'h0);
      pulse(2);
      reg_rd(`FCFM_ADDR_RXERR_CNT);
      check(got, 32'h1);
      reg_rd(`FCFM_ADDR_INVAL_CNT);
      check(got, 32'h2);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h0);
      $display("marked frame test done");
   endtask

   task automatic t_levels();
      logic [7:0] codes [4] = '{`FCFM_CODE_DESC, `FCFM_CODE_EE_RD, `FCFM_CODE_EE_UPD, `FCFM_CODE_INIT};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         lvl[i] <= 1'b1;
         repeat (5) @(posedge clk_in);
         lvl[i] <= 1'b0;
         repeat (4) @(posedge clk_in);
         #1 check({irq, fault_any}, 2'b01);
         reg_rd(`FCFM_ADDR_CODE);
         check(got, codes[i]);
         reg_rd(`FCFM_ADDR_FAULT);
         check(got, 32'h8 << i);
      end
      // Firmware version with a wrong major
      @(posedge clk_in);
      fw <= 16'h0812;
      repeat (5) @(posedge clk_in);
      fw <= 16'h0912;
      repeat (4) @(posedge clk_in);
      reg_rd(`FCFM_ADDR_CODE);
      check(got, `FCFM_CODE_INIT);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h40);
      $display("level fault test done");
   endtask

   task automatic t_sync();
      reg_wr(`FCFM_ADDR_CTRL, 32'h1);
      reg_wr(`FCFM_ADDR_MASK, 32'h1FF);
      @(posedge clk_in);
      frames <= 1'b1;
      run <= 1'b1;
      repeat (10000) @(posedge clk_in);
      reg_rd(`FCFM_ADDR_CYCLE);
      check(got, 32'h09C4);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h0);
      @(posedge clk_in);
      period <= 16'h09D8;
      repeat (8000) @(posedge clk_in);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h080);
      reg_wr(`FCFM_ADDR_THRESH, 32'h000A);
      repeat (8000) @(posedge clk_in);
      #1 check({irq, fault_any}, 2'b11);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h180);
      @(posedge clk_in);
      period <= 16'h09C4;
      repeat (8000) @(posedge clk_in);
      reg_rd(`FCFM_ADDR_FAULT);
      @(posedge clk_in);
      frames <= 1'b0;
      repeat (10000) @(posedge clk_in);
      reg_rd(`FCFM_ADDR_CODE);
      check(got, `FCFM_CODE_TIMEOUT);
      reg_rd(`FCFM_ADDR_FAULT);
      check(got, 32'h004);
      @(posedge clk_in);
      run <= 1'b0;
      reg_wr(`FCFM_ADDR_CTRL, 32'h0);
      $display("sync test done");
   endtask

   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_loss();
      t_marked();
      t_levels();
      t_sync();
      summarize();
   end

   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk_in);
      bad_count++;
      summarize();
   end
endmodule
